// file: shared/amg_pkg.sv
// package: register map, reset values and carried types of the alias/message/gpio bank
package amg_pkg;

  // register offsets
  localparam logic [7:0] OFS_ALIAS_SLOT6 = 8'h16;
  localparam logic [7:0] OFS_ALIAS_SLOT7 = 8'h17;
  localparam logic [7:0] OFS_MSG_A = 8'h18;
  localparam logic [7:0] OFS_MSG_B = 8'h19;
  localparam logic [7:0] OFS_GPIO_CFG = 8'h1a;

  // values after reset
  localparam logic [7:0] RST_ALIAS = 8'h00;
  localparam logic [7:0] RST_MSG_A = 8'h00;
  localparam logic [7:0] RST_MSG_B = 8'h01;
  localparam logic [7:0] RST_GPIO_CFG = 8'h00;

  // field positions
  localparam int ALIAS_MSB = 7;
  localparam int ALIAS_LSB = 1;
  localparam int GLB_LEVEL_BIT = 7;
  localparam int GLB_FORCE_DIR_BIT = 5;
  localparam int GLB_FORCE_EN_BIT = 4;
  localparam int PIN9_LEVEL_BIT = 3;
  localparam int PIN9_DIR_BIT = 1;
  localparam int PIN9_EN_BIT = 0;

  // a disabled alias slot
  localparam logic [6:0] ALIAS_OFF = 7'h00;

  // resolved pad behaviour
  typedef enum logic [1:0] {
    AMG_PAD_FUNCTIONAL,
    AMG_PAD_TRISTATE,
    AMG_PAD_DRIVE,
    AMG_PAD_INPUT
  } amg_pad_mode_t;

  // register access from the local serial-control slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } amg_reg_req_t;

  // global force controls handed to the other gpio pads
  typedef struct packed {
    logic level;
    logic force_dir;
    logic force_en;
  } amg_global_ctrl_t;

  // result of the alias lookup handed to the link forwarder
  typedef struct packed {
    logic valid;
    logic hit;
    logic slot7;
    logic [6:0] remote_addr;
  } amg_alias_result_t;

endpackage

// file: rtl/amg_regs.sv
// alias slots 6/7, two message registers and global force / pin 9 gpio control
`timescale 1ns/1ps

// Function
// - alias registers hold a 7-bit alias in bits 7..1 that selects remote targets
// - matched transactions are forwarded with address replaced by that slot's target id
// - an alias field of zero never matches
// - both message registers are plain 8-bit storage without side effects
// - reset loads message b with one, message a and aliases with zero
// - global level drives non-gpio pins while global enable with direction clear selects output
// - global {force_dir,force_en}: 00 functional, 10 tristate, 01 drive, 11 input
// - individual pin direction and enable override the global force pair
// - pin 9 {dir,en}: 00 follows the global pair, 10 tristate, 01 gpio output, 11 gpio input
// - pin 9 drives its local level only when enabled, output and remote off
// - remote control makes the pin an output carrying the remote value
module amg_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register access from the local serial-control slave
  input wire amg_pkg::amg_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // alias lookup request from the local bus decoder
  input wire logic lookup_valid,
  input wire logic [6:0] lookup_addr,
  input wire logic [6:0] target_id6,
  input wire logic [6:0] target_id7,
  output amg_pkg::amg_alias_result_t lookup_result,
  // pin 9 pad and its sources
  input wire logic pin9_remote_enable,
  input wire logic pin9_remote_level,
  input wire logic pin9_functional_level,
  input wire logic pin9_pad_in,
  output logic pin9_pad_out,
  output logic pin9_pad_oe,
  output logic pin9_sampled,
  output amg_pkg::amg_pad_mode_t pin9_mode,
  // global force controls for the other pads
  output amg_pkg::amg_global_ctrl_t global_ctrl
);

  // register contents
  logic [6:0] remote_target_alias_6;
  logic [6:0] remote_target_alias_7;
  logic [7:0] scratch_message_a;
  logic [7:0] scratch_message_b;
  logic [7:0] global_force_and_pin9_config;
  logic [6:0] next_alias_6;
  logic [6:0] next_alias_7;
  logic [7:0] next_msg_a;
  logic [7:0] next_msg_b;
  logic [7:0] next_gpio_cfg;
  logic [7:0] next_rdata;
  logic next_hit;

  // lookup and pad state
  amg_pkg::amg_alias_result_t next_result;
  amg_pkg::amg_pad_mode_t next_mode;
  logic next_pad_out;
  logic next_pad_oe;
  logic pad_sync1;
  logic pad_sync2;

  // a slot matches only when it is programmed and equal to the address
  function automatic logic alias_match(input logic [6:0] alias_val, input logic [6:0] addr);
    alias_match = (alias_val != amg_pkg::ALIAS_OFF) && (alias_val == addr);
  endfunction

  // a {dir,en} pair turned into a pad behaviour; shared by pin and global decode
  function automatic amg_pkg::amg_pad_mode_t pair_mode(input logic dir, input logic en);
    case ({dir, en})
      2'b00: pair_mode = amg_pkg::AMG_PAD_FUNCTIONAL;
      2'b10: pair_mode = amg_pkg::AMG_PAD_TRISTATE;
      2'b01: pair_mode = amg_pkg::AMG_PAD_DRIVE;
      default: pair_mode = amg_pkg::AMG_PAD_INPUT;
    endcase
  endfunction

  // register writes and read data
  always_comb
  begin
    next_alias_6 = remote_target_alias_6;
    next_alias_7 = remote_target_alias_7;
    next_msg_a = scratch_message_a;
    next_msg_b = scratch_message_b;
    next_gpio_cfg = global_force_and_pin9_config;
    next_rdata = reg_rdata;
    next_hit = 1'b0;
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        amg_pkg::OFS_ALIAS_SLOT6: next_alias_6 = reg_req.wdata[amg_pkg::ALIAS_MSB:amg_pkg::ALIAS_LSB];
        amg_pkg::OFS_ALIAS_SLOT7: next_alias_7 = reg_req.wdata[amg_pkg::ALIAS_MSB:amg_pkg::ALIAS_LSB];
        amg_pkg::OFS_MSG_A: next_msg_a = reg_req.wdata;
        amg_pkg::OFS_MSG_B: next_msg_b = reg_req.wdata;
        amg_pkg::OFS_GPIO_CFG: next_gpio_cfg = reg_req.wdata; // reserved bits 6 and 2 store too
        default: ;
      endcase
    end
    if (reg_req.rd)
    begin
      next_hit = 1'b1;
      case (reg_req.addr)
        amg_pkg::OFS_ALIAS_SLOT6: next_rdata = {remote_target_alias_6, 1'b0};
        amg_pkg::OFS_ALIAS_SLOT7: next_rdata = {remote_target_alias_7, 1'b0};
        amg_pkg::OFS_MSG_A: next_rdata = scratch_message_a;
        amg_pkg::OFS_MSG_B: next_rdata = scratch_message_b;
        amg_pkg::OFS_GPIO_CFG: next_rdata = global_force_and_pin9_config;
        default:
        begin
          next_rdata = 8'h00; // unmapped offsets read as zero
          next_hit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      remote_target_alias_6 <= amg_pkg::RST_ALIAS[amg_pkg::ALIAS_MSB:amg_pkg::ALIAS_LSB];
      remote_target_alias_7 <= amg_pkg::RST_ALIAS[amg_pkg::ALIAS_MSB:amg_pkg::ALIAS_LSB];
      scratch_message_a <= amg_pkg::RST_MSG_A;
      scratch_message_b <= amg_pkg::RST_MSG_B;
      global_force_and_pin9_config <= amg_pkg::RST_GPIO_CFG;
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end
    else
    begin
      remote_target_alias_6 <= next_alias_6;
      remote_target_alias_7 <= next_alias_7;
      scratch_message_a <= next_msg_a;
      scratch_message_b <= next_msg_b;
      global_force_and_pin9_config <= next_gpio_cfg;
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
    end
  end

  // alias lookup; slot 6 is checked first should both slots hold the same alias
  always_comb
  begin
    next_result = '0;
    next_result.valid = lookup_valid;
    if (lookup_valid && alias_match(remote_target_alias_6, lookup_addr))
    begin
      next_result.hit = 1'b1;
      next_result.remote_addr = target_id6;
    end
    else if (lookup_valid && alias_match(remote_target_alias_7, lookup_addr))
    begin
      next_result.hit = 1'b1;
      next_result.slot7 = 1'b1;
      next_result.remote_addr = target_id7;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      lookup_result <= '0;
    else
      lookup_result <= next_result;
  end

  // pad control; the pad input is asynchronous so it is synchronised before use
  always_comb
  begin
    logic pin_dir;
    logic pin_en;
    pin_dir = global_force_and_pin9_config[amg_pkg::PIN9_DIR_BIT];
    pin_en = global_force_and_pin9_config[amg_pkg::PIN9_EN_BIT];
    next_pad_out = 1'b0;
    next_pad_oe = 1'b0;
    if (pin9_remote_enable)
    begin
      next_mode = amg_pkg::AMG_PAD_DRIVE;
      next_pad_out = pin9_remote_level;
      next_pad_oe = 1'b1;
    end
    else if ({pin_dir, pin_en} != 2'b00)
    begin
      next_mode = pair_mode(pin_dir, pin_en);
      next_pad_out = global_force_and_pin9_config[amg_pkg::PIN9_LEVEL_BIT];
      next_pad_oe = (next_mode == amg_pkg::AMG_PAD_DRIVE);
    end
    else
    begin
      next_mode = pair_mode(global_force_and_pin9_config[amg_pkg::GLB_FORCE_DIR_BIT],
                            global_force_and_pin9_config[amg_pkg::GLB_FORCE_EN_BIT]);
      next_pad_oe = (next_mode == amg_pkg::AMG_PAD_DRIVE) ||
                    (next_mode == amg_pkg::AMG_PAD_FUNCTIONAL);
      if (next_mode == amg_pkg::AMG_PAD_DRIVE)
        next_pad_out = global_force_and_pin9_config[amg_pkg::GLB_LEVEL_BIT];
      else
        next_pad_out = pin9_functional_level;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pin9_pad_out <= 1'b0;
      pin9_pad_oe <= 1'b0;
      pin9_mode <= amg_pkg::AMG_PAD_FUNCTIONAL;
      pad_sync1 <= 1'b0;
      pad_sync2 <= 1'b0;
      pin9_sampled <= 1'b0;
      global_ctrl <= '0;
    end
    else
    begin
      pin9_pad_out <= next_pad_out;
      pin9_pad_oe <= next_pad_oe;
      pin9_mode <= next_mode;
      pad_sync1 <= pin9_pad_in;
      pad_sync2 <= pad_sync1;
      pin9_sampled <= pad_sync2;
      global_ctrl <= {global_force_and_pin9_config[amg_pkg::GLB_LEVEL_BIT],
                      global_force_and_pin9_config[amg_pkg::GLB_FORCE_DIR_BIT],
                      global_force_and_pin9_config[amg_pkg::GLB_FORCE_EN_BIT]};
    end
  end

endmodule

// file: tb/amg_regs_monitor.sv
// checker: lookup, read and pad relations of the register bank
`timescale 1ns/1ps
module amg_regs_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register and lookup side
  input wire amg_pkg::amg_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic lookup_valid,
  input wire logic [6:0] lookup_addr,
  input wire logic [6:0] target_id6,
  input wire logic [6:0] target_id7,
  input wire amg_pkg::amg_alias_result_t lookup_result,
  // pad side
  input wire logic pin9_remote_enable,
  input wire logic pin9_remote_level,
  input wire logic pin9_pad_out,
  input wire logic pin9_pad_oe,
  input wire amg_pkg::amg_global_ctrl_t global_ctrl
);
  logic [7:0] cfg;
  logic [7:0] next_cfg;
  // config shadow rebuilt from writes, since the byte is not a port
  always_comb next_cfg = (reg_req.wr && reg_req.addr == 8'h1a) ? reg_req.wdata : cfg;
  always_ff @(posedge clock) cfg <= rst ? 8'h00 : next_cfg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_zero_lookup;
    lookup_valid && lookup_addr == 7'h00;
  endsequence
  // pin pair idle and global pair forcing the pad to drive
  sequence s_global_owns_pad;
    !pin9_remote_enable && cfg[1:0] == 2'b00 && cfg[5:4] == 2'b01;
  endsequence
  chk_lookup_answer: assert property (lookup_valid |=> lookup_result.valid)
    else $error("lookup not answered next cycle");
  chk_remote_addr: assert property (lookup_result.hit |-> lookup_result.remote_addr ==
    (lookup_result.slot7 ? $past(target_id7) : $past(target_id6))) else $error("bad remap");
  chk_miss_zero: assert property (lookup_result.valid && !lookup_result.hit |->
    lookup_result.remote_addr == 7'h00) else $error("miss carries an address");
  chk_zero_alias: assert property (s_zero_lookup |=> !lookup_result.hit)
    else $error("zero alias matched");
  chk_alias_bit0: assert property (reg_req.rd && reg_req.addr inside {8'h16, 8'h17} |=>
    !reg_rdata[0]) else $error("alias bit 0 not zero");
  chk_read_hit: assert property (reg_req.rd |=>
    reg_hit == ($past(reg_req.addr) inside {[8'h16:8'h1a]})) else $error("read hit wrong");
  chk_pin_drive: assert property (!$past(pin9_remote_enable) && $past(cfg[1:0]) == 2'b01 |->
    pin9_pad_oe && pin9_pad_out == $past(cfg[3])) else $error("pin drive wrong");
  chk_pin_off: assert property (!$past(pin9_remote_enable) && $past(cfg[1]) |->
    !pin9_pad_oe) else $error("pad driven in tristate or input");
  chk_global_copy: assert property (global_ctrl ==
    {$past(cfg[7]), $past(cfg[5]), $past(cfg[4])}) else $error("global copy wrong");
  chk_remote_drive: assert property (pin9_remote_enable |=> pin9_pad_oe &&
    pin9_pad_out == $past(pin9_remote_level)) else $error("remote level not driven");
  chk_global_drive: assert property (s_global_owns_pad |=> pin9_pad_oe &&
    pin9_pad_out == $past(cfg[7])) else $error("global level not driven");
endmodule
bind amg_regs amg_regs_monitor u_mon (.clock, .rst, .reg_req, .reg_rdata, .reg_hit,
  .lookup_valid, .lookup_addr, .target_id6, .target_id7, .lookup_result,
  .pin9_remote_enable, .pin9_remote_level, .pin9_pad_out, .pin9_pad_oe, .global_ctrl);

// file: tb/amg_far_pad.sv
// far side of pin 9: the pad wire and an outside driver
`timescale 1ns/1ps
module amg_far_pad (
  // pad from the block
  input wire logic pin9_pad_out,
  input wire logic pin9_pad_oe,
  // outside level and the resolved wire
  input wire logic ext_level,
  output logic pin9_pad_in
);
  // the outside driver yields while the block drives, so no fight is modelled
  assign pin9_pad_in = pin9_pad_oe ? pin9_pad_out : ext_level;
endmodule

// file: tb/tb_top.sv
// testbench: reset values, read/write, alias lookup and pin 9 pad modes
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  amg_pkg::amg_reg_req_t reg_req = '0;
  logic lookup_valid = 1'b0;
  logic [6:0] lookup_addr = 7'h00, target_id6 = 7'h00, target_id7 = 7'h00;
  logic pin9_remote_enable = 1'b0, pin9_remote_level = 1'b0;
  logic pin9_functional_level = 1'b0, ext_level = 1'b0;
  logic pin9_pad_in, reg_hit, pin9_pad_out, pin9_pad_oe, pin9_sampled;
  logic [7:0] reg_rdata, a6, c, d;
  amg_pkg::amg_alias_result_t lookup_result;
  amg_pkg::amg_pad_mode_t pin9_mode;
  amg_pkg::amg_global_ctrl_t global_ctrl;
  logic [9:0] exp_q[$];
  logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [31:0] seed = 32'h00000054;
  int n_fail = 0;
  int check_count = 0;
  amg_regs dut (.clock, .rst, .reg_req, .reg_rdata, .reg_hit, .lookup_valid, .lookup_addr,
    .target_id6, .target_id7, .lookup_result, .pin9_remote_enable, .pin9_remote_level,
    .pin9_functional_level, .pin9_pad_in, .pin9_pad_out, .pin9_pad_oe, .pin9_sampled,
    .pin9_mode, .global_ctrl);
  amg_far_pad far (.pin9_pad_out, .pin9_pad_oe, .ext_level, .pin9_pad_in);
  always #50 clock = ~clock;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] ex);
    check_count++;
    if (seen !== ex)
    begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, ex);
    end
  endtask
  // one bus step per cycle; strobes stay up between steps so each edge takes one
  task automatic bus(input logic w, r, input logic [7:0] a, dat, ex);
    reg_req = '{wr: w, rd: r, addr: a, wdata: dat};
    if (r && a inside {[8'h16:8'h1a]}) exp_q.push_back({2'b00, ex});
    @(posedge clock);
    #1;
  endtask
  task automatic lk(input logic [6:0] a, input logic [9:0] ex);
    lookup_valid = 1'b1;
    lookup_addr = a;
    exp_q.push_back(ex);
    @(posedge clock);
    #1;
  endtask
  // results are matched in order against what the driver noted
  always @(negedge clock)
  begin
    if (reg_hit === 1'b1)
      check({2'b00, reg_rdata}, exp_q.size() ? exp_q.pop_front() : 10'h3ff);
    if (lookup_result.valid === 1'b1)
      check(lookup_result, exp_q.size() ? exp_q.pop_front() : 10'h000);
  end
  task automatic pad_chk(input logic [7:0] v);
    logic [1:0] p;
    logic lv;
    logic [3:0] e;
    p = (v[1:0] != 2'b00) ? v[1:0] : v[5:4];
    lv = (v[1:0] != 2'b00) ? v[3] : v[7];
    case (p)
      2'b00: e = {amg_pkg::AMG_PAD_FUNCTIONAL, 1'b1, pin9_functional_level};
      2'b01: e = {amg_pkg::AMG_PAD_DRIVE, 1'b1, lv};
      2'b10: e = {amg_pkg::AMG_PAD_TRISTATE, 2'b00};
      default: e = {amg_pkg::AMG_PAD_INPUT, 2'b00};
    endcase
    check({pin9_mode, pin9_pad_oe, pin9_pad_oe & pin9_pad_out}, e);
    check(global_ctrl, {v[7], v[5], v[4]});
    repeat (3) bus(0, 0, 8'h00, 8'h00, 8'h00);
    check(pin9_sampled, e[1] ? e[0] : ext_level);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (5000) @(posedge clock);
    n_fail++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
    bus(0, 0, 8'h00, 8'h00, 8'h00); // first request waits one edge past release
    for (int i = 0; i < 5; i++) bus(0, 1, 8'(8'h16 + i), 8'h00, rv[i]);
    for (int i = 0; i < 5; i++)
    begin
      d = rnd();
      bus(1, 0, 8'(8'h16 + i), d, 8'h00);
      bus(0, 1, 8'(8'h16 + i), 8'h00, (i < 2) ? (d & 8'hfe) : d);
    end
    bus(1, 1, 8'h1b, d, 8'h00);
    // mid-run reset must bring the reset values back over random contents
    rst = 1'b1;
    repeat (2) bus(0, 0, 8'h00, 8'h00, 8'h00);
    rst = 1'b0;
    bus(0, 0, 8'h00, 8'h00, 8'h00);
    for (int i = 0; i < 5; i++) bus(0, 1, 8'(8'h16 + i), 8'h00, rv[i]);
    d = rnd();
    target_id6 = d[6:0];
    d = rnd();
    target_id7 = d[6:0];
    d = rnd();
    a6 = {d[7:2], 2'b10};
    bus(1, 0, 8'h16, a6, 8'h00);
    bus(1, 0, 8'h17, a6 ^ 8'h80, 8'h00);
    bus(0, 0, 8'h00, 8'h00, 8'h00);
    lk(a6[7:1], {3'b110, target_id6});
    lk(a6[7:1] ^ 7'h40, {3'b111, target_id7});
    lk(a6[7:1] ^ 7'h02, 10'h200);
    lookup_valid = 1'b0;
    // both slots equal: slot 6 must win
    bus(1, 0, 8'h17, a6, 8'h00);
    lk(a6[7:1], {3'b110, target_id6});
    lookup_valid = 1'b0;
    bus(1, 0, 8'h17, 8'h00, 8'h00);
    bus(0, 0, 8'h00, 8'h00, 8'h00);
    lk(7'h00, 10'h200);
    lookup_valid = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      d = rnd();
      ext_level = d[0];
      pin9_functional_level = d[1];
      c = {d[7:6], 2'(i >> 2), d[3:2], 2'(i)};
      bus(1, 0, 8'h1a, c, 8'h00);
      bus(0, 1, 8'h1a, 8'h00, c);
      bus(0, 0, 8'h00, 8'h00, 8'h00);
      pad_chk(c);
    end
    pin9_remote_enable = 1'b1;
    // both remote levels, so a stuck drive value cannot pass
    for (int i = 0; i < 2; i++)
    begin
      pin9_remote_level = d[4] ^ i[0];
      repeat (2) bus(0, 0, 8'h00, 8'h00, 8'h00);
      check({pin9_mode, pin9_pad_oe, pin9_pad_out},
            {amg_pkg::AMG_PAD_DRIVE, 1'b1, pin9_remote_level});
    end
    pin9_remote_enable = 1'b0;
    repeat (3) bus(0, 0, 8'h00, 8'h00, 8'h00);
    if (exp_q.size() != 0) n_fail++;
    conclude();
  end
endmodule
